// *** pkg/palvc_pkg.sv ***
// constants and field types for the palette control register bank
package palvc_pkg;

  // ==========================================================
  // register indices on the host data-bus port
  localparam logic [7:0] PALVC_IDX_CURSOR_CTL = 8'h06;
  localparam logic [7:0] PALVC_IDX_GENERAL_CTL = 8'h1d;

  // ==========================================================
  // general control field positions
  localparam int PALVC_GC_OVS_SRC_BIT = 7;
  localparam int PALVC_GC_OVS_EN_BIT = 6;
  localparam int PALVC_GC_SOG_BIT = 5;
  localparam int PALVC_GC_PED_BIT = 4;
  localparam int PALVC_GC_ORDER_BIT = 3;
  localparam int PALVC_GC_SPLIT_BIT = 2;
  localparam int PALVC_GC_VPOL_BIT = 1;
  localparam int PALVC_GC_HPOL_BIT = 0;

  // cursor control field positions
  localparam int PALVC_CC_RSVD_BIT = 7;
  localparam int PALVC_CC_SPRITE_BIT = 6;
  localparam int PALVC_CC_DUAL_BIT = 5;
  localparam int PALVC_CC_FMT_BIT = 4;
  localparam int PALVC_CC_COLOUR_BIT = 3;
  localparam int PALVC_CC_XHAIR_BIT = 2;
  localparam int PALVC_CC_THICK_LSB = 0;

  // reset values and cursor control write mask
  localparam logic [7:0] PALVC_GENERAL_CTL_RST = 8'h20;
  localparam logic [7:0] PALVC_CURSOR_CTL_RST = 8'h00;
  localparam logic [7:0] PALVC_CURSOR_CTL_MASK = 8'h7f;

  // ==========================================================
  // timing
  localparam int PALVC_CLK_PERIOD_PS = 10000;
  localparam int PALVC_SPLIT_LATENCY_NS = 20;
  localparam int PALVC_SPLIT_HIGH_NS = 15;
  localparam int PALVC_SPLIT_LATENCY_CYC =
    (PALVC_SPLIT_LATENCY_NS * 1000 / PALVC_CLK_PERIOD_PS < 1) ? 1 :
    PALVC_SPLIT_LATENCY_NS * 1000 / PALVC_CLK_PERIOD_PS;
  localparam int PALVC_SPLIT_HIGH_CYC =
    (PALVC_SPLIT_HIGH_NS * 1000 + PALVC_CLK_PERIOD_PS - 1) / PALVC_CLK_PERIOD_PS;

  localparam int PALVC_COORD_W = 12;

  // ==========================================================
  // packed register images and pixel coordinate point
  typedef struct packed {
    logic overscan_source_select;
    logic overscan_border_enable;
    logic sync_on_green_enable;
    logic pedestal_select;
    logic pixel_byte_order;
    logic split_transfer_enable;
    logic vert_sync_polarity;
    logic horiz_sync_polarity;
  } palvc_gen_ctl_type;

  typedef struct packed {
    logic cursor_ctl_reserved;
    logic sprite_cursor_enable;
    logic dual_cursor_format;
    logic sprite_data_format;
    logic crosshair_colour_select;
    logic crosshair_enable;
    logic [1:0] crosshair_thickness;
  } palvc_cur_ctl_type;

  typedef struct packed {
    logic [PALVC_COORD_W-1:0] x;
    logic [PALVC_COORD_W-1:0] y;
  } palvc_point_type;

endpackage

// *** src/palvc_ctrl_regs.sv ***
// general and cursor control registers of the video palette
//
// Contract
// - general control at index 1d, read/write anytime
// - bit 7 picks overscan source pin/internal
// - bit 6 enables overscan borders, reset off
// - bit 5 puts sync on green, reset on
// - bit 4 selects 0 or 7.5 IRE pedestal
// - bit 3 selects little or big endian
// - bit 2 enables split transfer, reset off
// - bit 1 sets vertical sync polarity
// - bit 0 sets horizontal sync polarity
// - legacy port mode passes sync unchanged
// - extra shift clock on flag rising edge
// - cursor control at index 06, read/write anytime
// - bit 6 enables sprite cursor, reset off
// - bit 5 selects dual cursor format
// - bit 4 selects sprite data format
// - bit 3 selects crosshair colour
// - bit 2 enables crosshair, reset off
// - bits 1:0 give 1/3/5/7 pixel thickness
// - thick segments centred on cursor position
`timescale 1ns/1ps
module palvc_ctrl_regs (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // host indexed port
  input wire logic [7:0] mpu_index_i,
  input wire logic [7:0] mpu_wdata_i,
  input wire logic mpu_wr_i,
  input wire logic mpu_rd_i,
  output logic [7:0] mpu_rdata_o,
  output logic mpu_rvalid_o,
  // register images
  output palvc_pkg::palvc_gen_ctl_type general_ctl_o,
  output palvc_pkg::palvc_cur_ctl_type cursor_ctl_o,
  // sync path
  input wire logic legacy_port_mode_i,
  input wire logic horiz_sync_b_i,
  input wire logic vert_sync_b_i,
  output logic horiz_sync_out_o,
  output logic vert_sync_out_o,
  output logic green_sync_o,
  // overscan
  input wire logic overscan_input_pin_i,
  input wire logic overscan_internal_i,
  output logic overscan_active_o,
  // split transfer
  input wire logic split_transfer_flag_i,
  output logic split_shift_transfer_o,
  // crosshair
  input wire palvc_pkg::palvc_point_type pixel_pos_i,
  input wire palvc_pkg::palvc_point_type cursor_pos_i,
  output logic crosshair_hit_o,
  output logic crosshair_colour_o
);
  import palvc_pkg::*;

  // ==========================================================
  // register storage
  palvc_gen_ctl_type general_ctl_r;
  palvc_cur_ctl_type cursor_ctl_r;

  // general control write path
  // general control write
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      general_ctl_r <= palvc_gen_ctl_type'(PALVC_GENERAL_CTL_RST);
    end else if (mpu_wr_i && mpu_index_i == PALVC_IDX_GENERAL_CTL) begin
      general_ctl_r <= palvc_gen_ctl_type'(mpu_wdata_i);
    end
  end

  // cursor control write path
  // cursor control write
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cursor_ctl_r <= palvc_cur_ctl_type'(PALVC_CURSOR_CTL_RST);
    end else if (mpu_wr_i && mpu_index_i == PALVC_IDX_CURSOR_CTL) begin
      cursor_ctl_r <= palvc_cur_ctl_type'(mpu_wdata_i & PALVC_CURSOR_CTL_MASK);
    end
  end

  // ==========================================================
  // read path
  logic [7:0] rdata_nxt;

  always_comb begin
    unique case (mpu_index_i)
      PALVC_IDX_GENERAL_CTL: rdata_nxt = general_ctl_r;
      PALVC_IDX_CURSOR_CTL: rdata_nxt = cursor_ctl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mpu_rdata_o <= 8'h00;
      mpu_rvalid_o <= 1'b0;
    end else begin
      mpu_rvalid_o <= mpu_rd_i;
      if (mpu_rd_i) begin
        mpu_rdata_o <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // field outputs
  // pedestal field exported
  assign general_ctl_o = general_ctl_r;
  assign cursor_ctl_o = cursor_ctl_r;

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta_r <= 5'h03;
      pin_sync_r <= 5'h03;
    end else begin
      pin_meta_r <= {split_transfer_flag_i, overscan_input_pin_i,
                     legacy_port_mode_i, vert_sync_b_i, horiz_sync_b_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic hs_b_s;
  logic vs_b_s;
  logic legacy_s;
  logic ovs_pin_s;
  logic flag_s;

  assign hs_b_s = pin_sync_r[0];
  assign vs_b_s = pin_sync_r[1];
  assign legacy_s = pin_sync_r[2];
  assign ovs_pin_s = pin_sync_r[3];
  assign flag_s = pin_sync_r[4];

  // ==========================================================
  // sync outputs
  logic hs_out_nxt;
  logic vs_out_nxt;
  logic green_sync_nxt;

  always_comb begin
    if (legacy_s) begin
      hs_out_nxt = hs_b_s;
      vs_out_nxt = vs_b_s;
    end else begin
      hs_out_nxt = general_ctl_r.horiz_sync_polarity ? ~hs_b_s : hs_b_s;
      vs_out_nxt = general_ctl_r.vert_sync_polarity ? ~vs_b_s : vs_b_s;
    end
    green_sync_nxt = general_ctl_r.sync_on_green_enable & (~hs_b_s | ~vs_b_s);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      horiz_sync_out_o <= 1'b1;
      vert_sync_out_o <= 1'b1;
      green_sync_o <= 1'b0;
    end else begin
      horiz_sync_out_o <= hs_out_nxt;
      vert_sync_out_o <= vs_out_nxt;
      green_sync_o <= green_sync_nxt;
    end
  end

  // ==========================================================
  // overscan control
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overscan_active_o <= 1'b0;
    end else begin
      overscan_active_o <= general_ctl_r.overscan_border_enable &
        (general_ctl_r.overscan_source_select ? overscan_internal_i : ovs_pin_s);
    end
  end

  // ==========================================================
  // split transfer shift clock
  localparam logic [3:0] SPLIT_HIGH_CNT = 4'(PALVC_SPLIT_HIGH_CYC);
  logic flag_d_r;
  logic [3:0] split_cnt_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_d_r <= 1'b0;
    end else begin
      flag_d_r <= flag_s;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      split_cnt_r <= 4'h0;
    end else if (general_ctl_r.split_transfer_enable && flag_s && !flag_d_r) begin
      // enable gates pulse; start extra shift clock
      split_cnt_r <= SPLIT_HIGH_CNT;
    end else if (split_cnt_r != 4'h0) begin
      split_cnt_r <= split_cnt_r - 4'h1;
    end
  end

  assign split_shift_transfer_o = (split_cnt_r != 4'h0);

  // ==========================================================
  // crosshair hit test
  localparam int DW = PALVC_COORD_W + 1;

  function automatic logic [DW-1:0] abs_diff(input logic [PALVC_COORD_W-1:0] a,
                                             input logic [PALVC_COORD_W-1:0] b);
    logic [DW-1:0] d;
    d = {1'b0, a} - {1'b0, b};
    abs_diff = d[DW-1] ? (~d + 13'h0001) : d;
  endfunction

  logic [DW-1:0] half_w;
  logic [DW-1:0] dx;
  logic [DW-1:0] dy;
  logic hit_nxt;

  always_comb begin
    half_w = {11'h000, cursor_ctl_r.crosshair_thickness};
    dx = abs_diff(pixel_pos_i.x, cursor_pos_i.x);
    dy = abs_diff(pixel_pos_i.y, cursor_pos_i.y);
    hit_nxt = (dx <= half_w) || (dy <= half_w);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crosshair_hit_o <= 1'b0;
      crosshair_colour_o <= 1'b0;
    end else begin
      crosshair_hit_o <= cursor_ctl_r.crosshair_enable & hit_nxt;
      crosshair_colour_o <= cursor_ctl_r.crosshair_colour_select;
    end
  end

endmodule

// *** verification/palvc_ctrl_regs_properties.sv ***
// checker on the control register bank ports
`timescale 1ns/1ps
module palvc_ctrl_regs_chk (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] mpu_index_i,
  input wire logic [7:0] mpu_wdata_i,
  input wire logic mpu_wr_i,
  input wire logic mpu_rd_i,
  input wire logic [7:0] mpu_rdata_o,
  input wire logic mpu_rvalid_o,
  input wire palvc_pkg::palvc_gen_ctl_type general_ctl_o,
  input wire palvc_pkg::palvc_cur_ctl_type cursor_ctl_o,
  input wire logic legacy_port_mode_i,
  input wire logic horiz_sync_b_i,
  input wire logic horiz_sync_out_o,
  input wire logic overscan_internal_i,
  input wire logic overscan_active_o,
  input wire logic split_transfer_flag_i,
  input wire logic split_shift_transfer_o,
  input wire logic crosshair_hit_o,
  input wire logic crosshair_colour_o
);
  import palvc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // host port
  a_gen_write: assert property (
    mpu_wr_i && mpu_index_i == PALVC_IDX_GENERAL_CTL |=> general_ctl_o == $past(mpu_wdata_i)
  ) else $error("general write lost");
  a_cur_write: assert property (
    mpu_wr_i && mpu_index_i == PALVC_IDX_CURSOR_CTL
    |=> cursor_ctl_o == ($past(mpu_wdata_i) & 8'h7f)
  ) else $error("cursor write lost");
  a_gen_read: assert property (
    mpu_rd_i && mpu_index_i == PALVC_IDX_GENERAL_CTL
    |=> mpu_rvalid_o && mpu_rdata_o == $past(general_ctl_o)
  ) else $error("general read wrong");
  // ==========================================================
  // outputs
  a_hsync_map: assert property (
    horiz_sync_b_i == $past(horiz_sync_b_i, 3) && general_ctl_o == $past(general_ctl_o, 3)
    && legacy_port_mode_i == $past(legacy_port_mode_i, 3)
    |-> horiz_sync_out_o == (!legacy_port_mode_i && general_ctl_o.horiz_sync_polarity
    ? !horiz_sync_b_i : horiz_sync_b_i)
  ) else $error("hsync polarity wrong");
  a_ovs_off: assert property (
    !$past(general_ctl_o.overscan_border_enable) |-> !overscan_active_o
  ) else $error("overscan without enable");
  a_ovs_int: assert property (
    $past(general_ctl_o[7:6] == 2'b11) |-> overscan_active_o == $past(overscan_internal_i)
  ) else $error("internal overscan wrong");
  a_split_gate: assert property (
    $rose(split_shift_transfer_o) |-> $past(general_ctl_o.split_transfer_enable)
  ) else $error("split pulse while off");
  a_split_lat: assert property (
    $rose(split_transfer_flag_i) && general_ctl_o.split_transfer_enable
    |-> ##3 split_shift_transfer_o
  ) else $error("split pulse late");
  a_split_width: assert property (
    $rose(split_shift_transfer_o) |=> split_shift_transfer_o ##1 !split_shift_transfer_o
  ) else $error("split pulse width");
  a_xhair_off: assert property (
    !$past(cursor_ctl_o.crosshair_enable) |-> !crosshair_hit_o
  ) else $error("crosshair while off");
  a_colour_sel: assert property (
    crosshair_colour_o == $past(cursor_ctl_o.crosshair_colour_select)
  ) else $error("crosshair colour wrong");
endmodule
bind palvc_ctrl_regs palvc_ctrl_regs_chk u_chk (.clk_sys_i, .rst_b_i, .mpu_index_i,
  .mpu_wdata_i, .mpu_wr_i, .mpu_rd_i, .mpu_rdata_o, .mpu_rvalid_o, .general_ctl_o,
  .cursor_ctl_o, .legacy_port_mode_i, .horiz_sync_b_i, .horiz_sync_out_o,
  .overscan_internal_i, .overscan_active_o, .split_transfer_flag_i,
  .split_shift_transfer_o, .crosshair_hit_o, .crosshair_colour_o);

// *** verification/palvc_host_model.sv ***
// host processor model on the indexed register port
`timescale 1ns/1ps
module palvc_host_model (
  input wire logic clk_i,
  output logic [7:0] mpu_index_o,
  output logic [7:0] mpu_wdata_o,
  output logic mpu_wr_o,
  output logic mpu_rd_o,
  input wire logic [7:0] mpu_rdata_i,
  input wire logic mpu_rvalid_i
);
  initial begin
    mpu_index_o = 8'hff;
    mpu_wdata_o = 8'h00;
    mpu_wr_o = 1'b0;
    mpu_rd_o = 1'b0;
  end
  // ==========================================================
  // one byte per strobe; released data shows the inverse
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    mpu_index_o = i;
    mpu_wdata_o = d;
    mpu_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    mpu_wr_o = 1'b0;
    mpu_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    #1;
    mpu_index_o = i;
    mpu_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    mpu_rd_o = 1'b0;
    d = mpu_rdata_i;
    v = mpu_rvalid_i;
    mpu_index_o = ~i;
  endtask
endmodule

// *** verification/tb_palette_video_cursor_control_regs.sv ***
// self-checking bench for the control register bank
`timescale 1ns/1ps
module tb_palette_video_cursor_control_regs;
  import palvc_pkg::*;
  logic clk_sys_i, rst_b_i, legacy, hs, vs, ovs_pin, ovs_int, flag;
  logic [7:0] idx, wd, rdat;
  logic wr, rd, rv, hso, vso, gso, ovo, sst, hit, col;
  palvc_gen_ctl_type gen;
  palvc_cur_ctl_type cctl;
  palvc_point_type pix, cur;
  int error_cnt, n_checks, cyc, n;
  palvc_host_model h (.clk_i(clk_sys_i), .mpu_index_o(idx), .mpu_wdata_o(wd), .mpu_wr_o(wr),
    .mpu_rd_o(rd), .mpu_rdata_i(rdat), .mpu_rvalid_i(rv));
  palvc_ctrl_regs dut (.clk_sys_i, .rst_b_i, .mpu_index_i(idx), .mpu_wdata_i(wd),
    .mpu_wr_i(wr), .mpu_rd_i(rd), .mpu_rdata_o(rdat), .mpu_rvalid_o(rv), .general_ctl_o(gen),
    .cursor_ctl_o(cctl), .legacy_port_mode_i(legacy), .horiz_sync_b_i(hs),
    .vert_sync_b_i(vs), .horiz_sync_out_o(hso), .vert_sync_out_o(vso), .green_sync_o(gso),
    .overscan_input_pin_i(ovs_pin), .overscan_internal_i(ovs_int), .overscan_active_o(ovo),
    .split_transfer_flag_i(flag), .split_shift_transfer_o(sst), .pixel_pos_i(pix),
    .cursor_pos_i(cur), .crosshair_hit_o(hit), .crosshair_colour_o(col));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    h.rd(i, d, v);
    chk(v, 8'h01);
    chk(d, exp);
  endtask
  task automatic pulse(output int k);
    k = 0;
    repeat (8) begin
      tick(1);
      k += int'(sst === 1'b1);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {legacy, ovs_pin, ovs_int, flag} = 4'h0;
    {hs, vs} = 2'b11;
    cur = '{x: 12'h100, y: 12'h100};
    pix = cur;
    rst_b_i = 1'b0;
    tick(10);
    rst_b_i = 1'b1;
    rchk(PALVC_IDX_GENERAL_CTL, 8'h20);
    rchk(PALVC_IDX_CURSOR_CTL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      h.wr(8'h1d, 8'h01 << i);
      rchk(8'h1d, 8'h01 << i);
      h.wr(8'h06, 8'h01 << i);
      rchk(8'h06, (8'h01 << i) & 8'h7f);
    end
    h.wr(8'h07, 8'h55);
    rchk(8'h07, 8'h00);
    h.wr(8'h1d, 8'h18);
    tick(1);
    chk(gen.pedestal_select, 8'h01);
    chk(gen.pixel_byte_order, 8'h01);
    h.wr(8'h06, 8'h70);
    tick(1);
    chk(cctl.sprite_cursor_enable, 8'h01);
    chk(cctl.dual_cursor_format, 8'h01);
    chk(cctl.sprite_data_format, 8'h01);
    $display("test access done");
    for (int t = 0; t < 4; t++) begin
      h.wr(8'h06, {4'h0, t[0], 1'b1, t[1:0]});
      for (int d = -4; d < 5; d++) begin
        pix = '{x: 12'(256 + d), y: 12'h300};
        tick(2);
        chk(hit, d >= -t && d <= t);
        pix = '{x: 12'h300, y: 12'(256 + d)};
        tick(2);
        chk(hit, d >= -t && d <= t);
      end
      chk(col, t[0]);
    end
    h.wr(8'h06, 8'h03);
    pix = cur;
    tick(2);
    chk(hit, 8'h00);
    $display("test crosshair done");
    hs = 1'b0;
    for (int p = 0; p < 4; p++) begin
      h.wr(8'h1d, 8'(p));
      tick(4);
      chk(hso, p[0]);
      chk(vso, !p[1]);
    end
    legacy = 1'b1;
    tick(4);
    chk({hso, vso}, 8'h01);
    legacy = 1'b0;
    h.wr(8'h1d, 8'h20);
    tick(4);
    chk(gso, 8'h01);
    h.wr(8'h1d, 8'h00);
    tick(4);
    chk(gso, 8'h00);
    $display("test sync done");
    ovs_int = 1'b1;
    h.wr(8'h1d, 8'hc0);
    tick(2);
    chk(ovo, 8'h01);
    h.wr(8'h1d, 8'h40);
    tick(4);
    chk(ovo, 8'h00);
    ovs_pin = 1'b1;
    tick(4);
    chk(ovo, 8'h01);
    h.wr(8'h1d, 8'h80);
    tick(2);
    chk(ovo, 8'h00);
    $display("test overscan done");
    h.wr(8'h1d, 8'h04);
    flag = 1'b1;
    pulse(n);
    chk(8'(n), 8'h02);
    flag = 1'b0;
    h.wr(8'h1d, 8'h00);
    tick(3);
    flag = 1'b1;
    pulse(n);
    chk(8'(n), 8'h00);
    $display("test split done");
    tally_and_finish();
  end
endmodule
